/* hw/cpd_pkg.sv */
// Constants and types for the first operation word decoder
package cpd_pkg;

  // ------------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------------
  localparam int unsigned WORD_W = 16;

  // ------------------------------------------------------------------
  // Group codes, bits 15..12
  // ------------------------------------------------------------------
  localparam logic [3:0] GRP_BIT_IMM   = 4'h0;
  localparam logic [3:0] GRP_MOVE_B    = 4'h1;
  localparam logic [3:0] GRP_MOVE_L    = 4'h2;
  localparam logic [3:0] GRP_MOVE_W    = 4'h3;
  localparam logic [3:0] GRP_MISC      = 4'h4;
  localparam logic [3:0] GRP_QUICK     = 4'h5;
  localparam logic [3:0] GRP_BRANCH    = 4'h6;
  localparam logic [3:0] GRP_QLOAD     = 4'h7;
  localparam logic [3:0] GRP_OR_DIV    = 4'h8;
  localparam logic [3:0] GRP_SUB       = 4'h9;
  localparam logic [3:0] GRP_FREE_A    = 4'ha;
  localparam logic [3:0] GRP_CMP_XOR   = 4'hb;
  localparam logic [3:0] GRP_AND_MUL   = 4'hc;
  localparam logic [3:0] GRP_ADD       = 4'hd;
  localparam logic [3:0] GRP_SHIFT     = 4'he;
  localparam logic [3:0] GRP_FREE_F    = 4'hf;

  // ------------------------------------------------------------------
  // Size codes on the output
  // ------------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_NONE = 2'h3;

  // ------------------------------------------------------------------
  // Fixed patterns
  // ------------------------------------------------------------------
  localparam logic [3:0] COND_SUBROUTINE = 4'h1;
  localparam logic [2:0] MODE_ADDR_REG   = 3'h1;
  localparam logic [2:0] MODE_DATA_REG   = 3'h0;
  localparam logic [3:0] STATIC_BIT_SEL  = 4'h8;
  localparam logic [5:0] EXCH_DATA_PAT   = 6'h28;
  localparam logic [5:0] EXCH_ADDR_PAT   = 6'h29;
  localparam logic [5:0] EXCH_MIXED_PAT  = 6'h31;

  // ------------------------------------------------------------------
  // Decoded operation
  // ------------------------------------------------------------------
  typedef enum logic [6:0] {
    OP_ILLEGAL, OP_BIT_DYNAMIC, OP_BIT_STATIC, OP_PERIPH_MOVE,
    OP_IMM_OR, OP_IMM_AND, OP_IMM_SUB, OP_IMM_ADD, OP_IMM_XOR, OP_IMM_CMP,
    OP_MOVE, OP_NEG_EXTEND, OP_CLEAR, OP_NEGATE, OP_COMPLEMENT, OP_TEST,
    OP_FROM_STATUS, OP_TO_CODES, OP_TO_STATUS, OP_TEST_SET,
    OP_DEC_NEG, OP_PUSH_ADDR, OP_SWAP_HALVES, OP_SIGN_EXT_W, OP_SIGN_EXT_L,
    OP_LIST_MOVE, OP_RESET_EXT, OP_NO_OP, OP_STOP, OP_RETURN_EXC,
    OP_RETURN_SUB, OP_TRAP_OVF, OP_RETURN_CODES, OP_TRAP, OP_LINK,
    OP_UNLINK, OP_STACK_MOVE, OP_JUMP_SUB, OP_JUMP, OP_CHECK, OP_LOAD_ADDR,
    OP_ADD_QUICK, OP_SUB_QUICK, OP_COND_SET, OP_DEC_BRANCH,
    OP_COND_BRANCH, OP_BRANCH_SUB, OP_QUICK_LOAD,
    OP_OR, OP_DIV_UNSIGNED, OP_DIV_SIGNED, OP_DEC_SUB,
    OP_SUB, OP_SUB_EXT, OP_CMP, OP_MEM_COMPARE, OP_XOR,
    OP_AND, OP_MUL_UNSIGNED, OP_MUL_SIGNED, OP_DEC_ADD,
    OP_EXCH_DATA, OP_EXCH_ADDR, OP_EXCH_MIXED,
    OP_ADD, OP_ADD_EXT, OP_SHIFT
  } cpd_op_t;

endpackage : cpd_pkg

/* hw/cpd_word_if.sv */
// Carrier of the held operation word between the decoder's modules
`timescale 1ns/1ps
interface cpd_word_if;
  logic [15:0] word;
  logic        valid;

  modport holder (output word, output valid);
  modport user   (input  word, input  valid);
endinterface : cpd_word_if

/* hw/cpd_word_reg.sv */
// Decode register holding the operation word under decode
`timescale 1ns/1ps
module cpd_word_reg (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Word from the prefetch stage
  input  wire logic [15:0] word_i,
  input  wire logic        load_i,
  // Held word
  cpd_word_if.holder       held
);

  // ------------------------------------------------------------------
  // Word held until the next load, so fields stay stable
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held.word  <= 16'h0000;
      held.valid <= 1'b0;
    end else begin
      held.valid <= load_i;
      if (load_i) begin
        held.word <= word_i;
      end
    end
  end

endmodule : cpd_word_reg

/* hw/cpd_decoder.sv */
// First operation word decoder: classification and field extraction
`timescale 1ns/1ps
module cpd_decoder #(
  parameter int unsigned WORD_W = cpd_pkg::WORD_W
) (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_I,
  // Word from the prefetch stage
  input  wire logic [15:0] WORD_I,
  input  wire logic        LOAD_I,
  // Decoded result
  output logic             VALID_O,
  output logic             ILLEGAL_O,
  output logic [3:0]       GROUP_O,
  output logic [6:0]       OP_O,
  output logic [1:0]       SIZE_O,
  // Extracted fields
  output logic [2:0]       REG_HI_O,
  output logic [2:0]       REG_LO_O,
  output logic [2:0]       DST_MODE_O,
  output logic [2:0]       SRC_MODE_O,
  output logic [3:0]       COND_O,
  output logic [7:0]       DISP_O,
  output logic [7:0]       QUICK_O,
  output logic [3:0]       VECTOR_O,
  output logic [1:0]       KIND_O,
  output logic             DIR_O,
  output logic             MEM_FORM_O
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (WORD_W != 16) begin : g_bad_width
    $error("Only a 16-bit operation word can be decoded");
  end

  // ------------------------------------------------------------------
  // Decode register
  // ------------------------------------------------------------------
  cpd_word_if held_if ();

  cpd_word_reg u_word_reg (
    .clk_i  (REF_CLK_I),
    .rst_i  (RESET_I),
    .word_i (WORD_I),
    .load_i (LOAD_I),
    .held   (held_if.holder)
  );

  logic [15:0] w;
  logic        hv;
  logic [3:0]  grp;
  logic [2:0]  opm;
  logic [1:0]  szf;
  assign w   = held_if.word;
  assign hv  = held_if.valid;
  assign grp = w[15:12];
  assign opm = w[8:6];
  assign szf = w[7:6];

  // ------------------------------------------------------------------
  // Size helpers
  // ------------------------------------------------------------------
  function automatic logic [1:0] opmode_size(input logic [2:0] m);
    unique case (m[1:0])
      2'h0:    opmode_size = cpd_pkg::SZ_BYTE;
      2'h1:    opmode_size = cpd_pkg::SZ_WORD;
      2'h2:    opmode_size = cpd_pkg::SZ_LONG;
      default: opmode_size = m[2] ? cpd_pkg::SZ_LONG : cpd_pkg::SZ_WORD;
    endcase
  endfunction : opmode_size

  function automatic logic [1:0] flag_size(input logic f);
    flag_size = f ? cpd_pkg::SZ_LONG : cpd_pkg::SZ_WORD;
  endfunction : flag_size

  // ------------------------------------------------------------------
  // Operation classification
  // ------------------------------------------------------------------
  function automatic cpd_pkg::cpd_op_t classify(input logic [15:0] x);
    cpd_pkg::cpd_op_t op;
    logic             sz11;
    logic             ar_form;
    op      = cpd_pkg::OP_ILLEGAL;
    sz11    = (x[7:6] == 2'h3);
    ar_form = (x[5:3] == cpd_pkg::MODE_ADDR_REG);
    unique case (x[15:12])
      cpd_pkg::GRP_BIT_IMM: begin
        if (x[8] && ar_form) begin
          op = cpd_pkg::OP_PERIPH_MOVE;
        end else if (x[8]) begin
          op = cpd_pkg::OP_BIT_DYNAMIC;
        end else if (x[11:8] == cpd_pkg::STATIC_BIT_SEL) begin
          op = cpd_pkg::OP_BIT_STATIC;
        end else if (!sz11) begin
          unique case (x[11:8])
            4'h0:    op = cpd_pkg::OP_IMM_OR;
            4'h2:    op = cpd_pkg::OP_IMM_AND;
            4'h4:    op = cpd_pkg::OP_IMM_SUB;
            4'h6:    op = cpd_pkg::OP_IMM_ADD;
            4'ha:    op = cpd_pkg::OP_IMM_XOR;
            4'hc:    op = cpd_pkg::OP_IMM_CMP;
            default: op = cpd_pkg::OP_ILLEGAL;
          endcase
        end
      end
      cpd_pkg::GRP_MOVE_B, cpd_pkg::GRP_MOVE_L, cpd_pkg::GRP_MOVE_W: begin
        op = cpd_pkg::OP_MOVE;
      end
      cpd_pkg::GRP_MISC: begin
        if (x[8]) begin
          if (x[7:6] == 2'h2) op = cpd_pkg::OP_CHECK;
          if (x[7:6] == 2'h3) op = cpd_pkg::OP_LOAD_ADDR;
        end else begin
          unique case (x[11:9])
            3'h0: op = sz11 ? cpd_pkg::OP_FROM_STATUS
                            : cpd_pkg::OP_NEG_EXTEND;
            3'h1: op = sz11 ? cpd_pkg::OP_ILLEGAL : cpd_pkg::OP_CLEAR;
            3'h2: op = sz11 ? cpd_pkg::OP_TO_CODES : cpd_pkg::OP_NEGATE;
            3'h3: op = sz11 ? cpd_pkg::OP_TO_STATUS
                            : cpd_pkg::OP_COMPLEMENT;
            3'h5: op = sz11 ? cpd_pkg::OP_TEST_SET : cpd_pkg::OP_TEST;
            3'h4: begin
              if (x[7:6] == 2'h0) begin
                op = cpd_pkg::OP_DEC_NEG;
              end else if (x[7:6] == 2'h1) begin
                op = (x[5:3] == cpd_pkg::MODE_DATA_REG)
                   ? cpd_pkg::OP_SWAP_HALVES : cpd_pkg::OP_PUSH_ADDR;
              end else if (x[5:3] == cpd_pkg::MODE_DATA_REG) begin
                op = x[6] ? cpd_pkg::OP_SIGN_EXT_L : cpd_pkg::OP_SIGN_EXT_W;
              end else begin
                op = cpd_pkg::OP_LIST_MOVE;
              end
            end
            3'h6: begin
              if (x[7]) op = cpd_pkg::OP_LIST_MOVE;
            end
            default: begin
              unique case (x[7:6])
                2'h2: op = cpd_pkg::OP_JUMP_SUB;
                2'h3: op = cpd_pkg::OP_JUMP;
                2'h1: begin
                  unique case (x[5:4])
                    2'h0: op = cpd_pkg::OP_TRAP;
                    2'h1: op = x[3] ? cpd_pkg::OP_UNLINK : cpd_pkg::OP_LINK;
                    2'h2: op = cpd_pkg::OP_STACK_MOVE;
                    default: begin
                      if (!x[3]) begin
                        unique case (x[2:0])
                          3'h0:    op = cpd_pkg::OP_RESET_EXT;
                          3'h1:    op = cpd_pkg::OP_NO_OP;
                          3'h2:    op = cpd_pkg::OP_STOP;
                          3'h3:    op = cpd_pkg::OP_RETURN_EXC;
                          3'h5:    op = cpd_pkg::OP_RETURN_SUB;
                          3'h6:    op = cpd_pkg::OP_TRAP_OVF;
                          3'h7:    op = cpd_pkg::OP_RETURN_CODES;
                          default: op = cpd_pkg::OP_ILLEGAL;
                        endcase
                      end
                    end
                  endcase
                end
                default: op = cpd_pkg::OP_ILLEGAL;
              endcase
            end
          endcase
        end
      end
      cpd_pkg::GRP_QUICK: begin
        if (sz11) begin
          op = ar_form ? cpd_pkg::OP_DEC_BRANCH : cpd_pkg::OP_COND_SET;
        end else begin
          op = x[8] ? cpd_pkg::OP_SUB_QUICK : cpd_pkg::OP_ADD_QUICK;
        end
      end
      cpd_pkg::GRP_BRANCH: begin
        op = (x[11:8] == cpd_pkg::COND_SUBROUTINE)
           ? cpd_pkg::OP_BRANCH_SUB : cpd_pkg::OP_COND_BRANCH;
      end
      cpd_pkg::GRP_QLOAD: begin
        if (!x[8]) op = cpd_pkg::OP_QUICK_LOAD;
      end
      cpd_pkg::GRP_OR_DIV, cpd_pkg::GRP_AND_MUL: begin
        if (x[7:6] == 2'h3) begin
          if (x[15:12] == cpd_pkg::GRP_OR_DIV) begin
            op = x[8] ? cpd_pkg::OP_DIV_SIGNED : cpd_pkg::OP_DIV_UNSIGNED;
          end else begin
            op = x[8] ? cpd_pkg::OP_MUL_SIGNED : cpd_pkg::OP_MUL_UNSIGNED;
          end
        end else if (x[8:4] == 5'h10) begin
          op = (x[15:12] == cpd_pkg::GRP_OR_DIV)
             ? cpd_pkg::OP_DEC_SUB : cpd_pkg::OP_DEC_ADD;
        end else if (x[15:12] == cpd_pkg::GRP_AND_MUL &&
                     x[8:3] == cpd_pkg::EXCH_DATA_PAT) begin
          op = cpd_pkg::OP_EXCH_DATA;
        end else if (x[15:12] == cpd_pkg::GRP_AND_MUL &&
                     x[8:3] == cpd_pkg::EXCH_ADDR_PAT) begin
          op = cpd_pkg::OP_EXCH_ADDR;
        end else if (x[15:12] == cpd_pkg::GRP_AND_MUL &&
                     x[8:3] == cpd_pkg::EXCH_MIXED_PAT) begin
          op = cpd_pkg::OP_EXCH_MIXED;
        end else begin
          op = (x[15:12] == cpd_pkg::GRP_OR_DIV)
             ? cpd_pkg::OP_OR : cpd_pkg::OP_AND;
        end
      end
      cpd_pkg::GRP_SUB, cpd_pkg::GRP_ADD: begin
        if (x[8] && !sz11 && x[5:4] == 2'h0) begin
          op = (x[15:12] == cpd_pkg::GRP_SUB)
             ? cpd_pkg::OP_SUB_EXT : cpd_pkg::OP_ADD_EXT;
        end else begin
          op = (x[15:12] == cpd_pkg::GRP_SUB)
             ? cpd_pkg::OP_SUB : cpd_pkg::OP_ADD;
        end
      end
      cpd_pkg::GRP_CMP_XOR: begin
        if (!x[8] || sz11) begin
          op = cpd_pkg::OP_CMP;
        end else begin
          op = ar_form ? cpd_pkg::OP_MEM_COMPARE : cpd_pkg::OP_XOR;
        end
      end
      cpd_pkg::GRP_SHIFT: begin
        if (!sz11 || !x[11]) op = cpd_pkg::OP_SHIFT;
      end
      default: op = cpd_pkg::OP_ILLEGAL;
    endcase
    classify = op;
  endfunction : classify

  // ------------------------------------------------------------------
  // Field selection
  // ------------------------------------------------------------------
  cpd_pkg::cpd_op_t next_op;
  logic [1:0]       next_size;
  logic [1:0]       next_kind;
  logic [7:0]       next_quick;
  logic             next_dir;
  logic             next_mem_form;
  logic             is_move;
  logic             is_opmode;
  logic             is_sizefield;

  assign next_op   = classify(w);
  assign is_move   = (next_op == cpd_pkg::OP_MOVE);
  assign is_opmode = next_op inside {cpd_pkg::OP_OR, cpd_pkg::OP_AND,
                                     cpd_pkg::OP_SUB, cpd_pkg::OP_ADD,
                                     cpd_pkg::OP_CMP};
  assign is_sizefield = next_op inside {
    cpd_pkg::OP_IMM_OR, cpd_pkg::OP_IMM_AND, cpd_pkg::OP_IMM_SUB,
    cpd_pkg::OP_IMM_ADD, cpd_pkg::OP_IMM_XOR, cpd_pkg::OP_IMM_CMP,
    cpd_pkg::OP_NEG_EXTEND, cpd_pkg::OP_CLEAR, cpd_pkg::OP_NEGATE,
    cpd_pkg::OP_COMPLEMENT, cpd_pkg::OP_TEST, cpd_pkg::OP_ADD_QUICK,
    cpd_pkg::OP_SUB_QUICK, cpd_pkg::OP_SUB_EXT, cpd_pkg::OP_ADD_EXT,
    cpd_pkg::OP_MEM_COMPARE, cpd_pkg::OP_XOR, cpd_pkg::OP_SHIFT};

  // Move groups use their own size coding, so they are mapped apart
  assign next_size =
      is_move ? ((grp == cpd_pkg::GRP_MOVE_B) ? cpd_pkg::SZ_BYTE :
                 (grp == cpd_pkg::GRP_MOVE_L) ? cpd_pkg::SZ_LONG :
                 cpd_pkg::SZ_WORD) :
      (next_op == cpd_pkg::OP_LIST_MOVE) ? flag_size(w[6]) :
      (next_op == cpd_pkg::OP_PERIPH_MOVE) ? flag_size(w[6]) :
      (next_op inside {cpd_pkg::OP_SIGN_EXT_W, cpd_pkg::OP_SIGN_EXT_L}) ?
        flag_size(w[6]) :
      is_opmode ? opmode_size(opm) :
      (is_sizefield && szf != 2'h3) ? szf :
      cpd_pkg::SZ_NONE;

  // Memory shifts carry their type in bits 10..9
  assign next_kind =
      (next_op inside {cpd_pkg::OP_BIT_DYNAMIC, cpd_pkg::OP_BIT_STATIC}) ?
        w[7:6] :
      (next_op == cpd_pkg::OP_SHIFT) ?
        ((szf == 2'h3) ? w[10:9] : w[4:3]) :
      2'h0;

  assign next_quick =
      (next_op == cpd_pkg::OP_QUICK_LOAD) ? w[7:0] :
      (next_op inside {cpd_pkg::OP_ADD_QUICK, cpd_pkg::OP_SUB_QUICK}) ?
        {5'h00, w[11:9]} :
      8'h00;

  assign next_dir =
      (next_op == cpd_pkg::OP_LIST_MOVE)   ? w[10] :
      (next_op == cpd_pkg::OP_SHIFT)       ? w[8]  :
      (next_op == cpd_pkg::OP_STACK_MOVE)  ? w[3]  :
      (next_op == cpd_pkg::OP_PERIPH_MOVE) ? w[7]  :
      is_opmode                            ? w[8]  :
      1'b0;

  assign next_mem_form = (next_op inside {cpd_pkg::OP_DEC_ADD,
                          cpd_pkg::OP_DEC_SUB, cpd_pkg::OP_SUB_EXT,
                          cpd_pkg::OP_ADD_EXT}) ? w[3] : 1'b0;

  // ------------------------------------------------------------------
  // Output stage, one clock after the word is held
  // ------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      VALID_O    <= 1'b0;
      ILLEGAL_O  <= 1'b0;
      OP_O       <= 7'h00;
      SIZE_O     <= cpd_pkg::SZ_NONE;
      KIND_O     <= 2'h0;
      QUICK_O    <= 8'h00;
      DIR_O      <= 1'b0;
      MEM_FORM_O <= 1'b0;
    end else begin
      VALID_O    <= hv;
      ILLEGAL_O  <= (next_op == cpd_pkg::OP_ILLEGAL);
      OP_O       <= next_op;
      SIZE_O     <= next_size;
      KIND_O     <= next_kind;
      QUICK_O    <= next_quick;
      DIR_O      <= next_dir;
      MEM_FORM_O <= next_mem_form;
    end
  end

  // Raw fields need no reset value beyond the held word's
  always_ff @(posedge REF_CLK_I) begin
    GROUP_O    <= grp;
    REG_HI_O   <= w[11:9];
    DST_MODE_O <= w[8:6];
    SRC_MODE_O <= w[5:3];
    REG_LO_O   <= w[2:0];
    COND_O     <= w[11:8];
    DISP_O     <= w[7:0];
    VECTOR_O   <= w[3:0];
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [15:0] chk_word;
  always_ff @(posedge REF_CLK_I) begin
    chk_word <= w;
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  a_decode_latency: assert property (hv |=> VALID_O)
    else $error("decode result late");
  a_unassigned_grp: assert property (
    hv && (w[15:12] == 4'ha || w[15:12] == 4'hf) |=> ILLEGAL_O && VALID_O)
    else $error("unassigned group not flagged");
  a_move_fields: assert property (
    hv && w[15:12] == 4'h1 |=> OP_O == cpd_pkg::OP_MOVE &&
      SIZE_O == 2'h0 && REG_HI_O == chk_word[11:9] &&
      DST_MODE_O == chk_word[8:6] && SRC_MODE_O == chk_word[5:3])
    else $error("byte move fields wrong");
  a_quick_load: assert property (
    hv && w[15:12] == 4'h7 |=> (OP_O == cpd_pkg::OP_QUICK_LOAD) ==
      !chk_word[8] && (chk_word[8] || QUICK_O == chk_word[7:0]))
    else $error("quick load decode wrong");
  a_branch_sub: assert property (
    hv && w[15:8] == 8'h61 |=> OP_O == cpd_pkg::OP_BRANCH_SUB &&
      DISP_O == chk_word[7:0])
    else $error("subroutine branch not decoded");
  a_fixed_noop: assert property (
    hv && w == 16'h4e71 |=> OP_O == cpd_pkg::OP_NO_OP && !ILLEGAL_O ##1
      ($past(hv) || (!VALID_O && OP_O == cpd_pkg::OP_NO_OP)))
    else $error("no operation word not decoded");
  a_exchange_mix: assert property (
    hv && w[15:12] == 4'hc && w[8:3] == 6'h31 |=>
      OP_O == cpd_pkg::OP_EXCH_MIXED && REG_LO_O == chk_word[2:0])
    else $error("mixed exchange not decoded");
  a_dec_branch: assert property (
    hv && w[15:12] == 4'h5 && w[7:3] == 5'h19 |=>
      OP_O == cpd_pkg::OP_DEC_BRANCH && COND_O == chk_word[11:8])
    else $error("decrement branch not decoded");
  a_divide_mode: assert property (
    hv && w[15:12] == 4'h8 && w[7:6] == 2'h3 |=> OP_O ==
      (chk_word[8] ? cpd_pkg::OP_DIV_SIGNED : cpd_pkg::OP_DIV_UNSIGNED))
    else $error("divide op-mode wrong");
  a_static_bit: assert property (
    hv && w[15:8] == 8'h08 |=> OP_O == cpd_pkg::OP_BIT_STATIC &&
      KIND_O == chk_word[7:6])
    else $error("static bit op wrong");
  a_list_dir: assert property (
    hv && w[15:11] == 5'h09 && w[9:7] == 3'h1 && w[5:3] != 3'h0 |=>
      OP_O == cpd_pkg::OP_LIST_MOVE && DIR_O == chk_word[10] &&
      SIZE_O == (chk_word[6] ? 2'h2 : 2'h1))
    else $error("list move decode wrong");

  c_illegal:  cover property (hv ##1 ILLEGAL_O);
  c_branch:   cover property (VALID_O && OP_O == cpd_pkg::OP_COND_BRANCH);
  c_list:     cover property (VALID_O && OP_O == cpd_pkg::OP_LIST_MOVE);
  c_back2back: cover property (hv ##1 hv);

endmodule : cpd_decoder

/* verif/cpd_fetch_model.sv */
// Prefetch stage model feeding operation words
`timescale 1ns/1ps
module cpd_fetch_model (
  // Clock and pacing
  input  wire logic        clk_i,
  input  wire logic        stall_i,
  // Words toward the decoder
  output logic [15:0]      word_o,
  output logic             load_o
);
  logic [15:0] fifo [$];
  initial begin
    word_o = 16'h0;
    load_o = 1'b0;
  end
  // Idle cycles churn the word so a stale value never looks fresh
  always @(negedge clk_i) begin
    if (fifo.size() != 0 && !stall_i) begin
      load_o <= 1'b1;
      word_o <= fifo.pop_front();
    end else begin
      load_o <= 1'b0;
      word_o <= ~word_o;
    end
  end
  task automatic push(input logic [15:0] w);
    fifo.push_back(w);
  endtask : push
endmodule : cpd_fetch_model

/* verif/cpd_decoder_tb.sv */
// Self-checking bench for the first operation word decoder
`timescale 1ns/1ps
module cpd_decoder_tb;
  logic REF_CLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic stall = 1'b0;
  logic [15:0] WORD_I, w1, w2;
  logic LOAD_I, VALID_O, ILLEGAL_O, DIR_O, MEM_FORM_O;
  logic l1 = 1'b0;
  logic l2 = 1'b0;
  logic [3:0] GROUP_O, COND_O, VECTOR_O;
  logic [6:0] OP_O;
  logic [1:0] SIZE_O, KIND_O;
  logic [2:0] REG_HI_O, REG_LO_O, DST_MODE_O, SRC_MODE_O;
  logic [7:0] DISP_O, QUICK_O;
  int err_count = 0;
  int num_checks = 0;
  cpd_pkg::cpd_op_t eop [logic [15:0]];
  logic [15:0] cw [$] = '{16'h4e71, 16'h4e70, 16'h4e72, 16'h4e73, 16'h4e75,
    16'h4e76, 16'h4e77, 16'h4e4f, 16'h4e5a, 16'h4e63, 16'h4810, 16'h4842,
    16'h48c2, 16'h4890, 16'h40d0, 16'h4ad0, 16'h0310, 16'h0850, 16'h0308,
    16'h0a10, 16'h5310, 16'h57d0, 16'h57c9, 16'h6105, 16'h6705, 16'h7305,
    16'h83d0, 16'h8301, 16'hb308, 16'hb310, 16'hc389, 16'he350};
  cpd_pkg::cpd_op_t co [$] = '{cpd_pkg::OP_NO_OP, cpd_pkg::OP_RESET_EXT,
    cpd_pkg::OP_STOP, cpd_pkg::OP_RETURN_EXC, cpd_pkg::OP_RETURN_SUB,
    cpd_pkg::OP_TRAP_OVF, cpd_pkg::OP_RETURN_CODES, cpd_pkg::OP_TRAP,
    cpd_pkg::OP_UNLINK, cpd_pkg::OP_STACK_MOVE, cpd_pkg::OP_DEC_NEG,
    cpd_pkg::OP_SWAP_HALVES, cpd_pkg::OP_SIGN_EXT_L, cpd_pkg::OP_LIST_MOVE,
    cpd_pkg::OP_FROM_STATUS, cpd_pkg::OP_TEST_SET, cpd_pkg::OP_BIT_DYNAMIC,
    cpd_pkg::OP_BIT_STATIC, cpd_pkg::OP_PERIPH_MOVE, cpd_pkg::OP_IMM_XOR,
    cpd_pkg::OP_SUB_QUICK, cpd_pkg::OP_COND_SET, cpd_pkg::OP_DEC_BRANCH,
    cpd_pkg::OP_BRANCH_SUB, cpd_pkg::OP_COND_BRANCH, cpd_pkg::OP_ILLEGAL,
    cpd_pkg::OP_DIV_SIGNED, cpd_pkg::OP_DEC_SUB, cpd_pkg::OP_MEM_COMPARE,
    cpd_pkg::OP_XOR, cpd_pkg::OP_EXCH_MIXED, cpd_pkg::OP_SHIFT};
  cpd_fetch_model fm (.clk_i(REF_CLK_I), .stall_i(stall), .word_o(WORD_I),
    .load_o(LOAD_I));
  cpd_decoder dut (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .WORD_I(WORD_I),
    .LOAD_I(LOAD_I), .VALID_O(VALID_O), .ILLEGAL_O(ILLEGAL_O),
    .GROUP_O(GROUP_O), .OP_O(OP_O), .SIZE_O(SIZE_O), .REG_HI_O(REG_HI_O),
    .REG_LO_O(REG_LO_O), .DST_MODE_O(DST_MODE_O), .SRC_MODE_O(SRC_MODE_O),
    .COND_O(COND_O), .DISP_O(DISP_O), .QUICK_O(QUICK_O),
    .VECTOR_O(VECTOR_O), .KIND_O(KIND_O), .DIR_O(DIR_O),
    .MEM_FORM_O(MEM_FORM_O));
  always #50 REF_CLK_I = ~REF_CLK_I;
  function automatic logic [1:0] msz(input logic [3:0] g);
    return g == 4'h1 ? cpd_pkg::SZ_BYTE :
           g == 4'h3 ? cpd_pkg::SZ_WORD : cpd_pkg::SZ_LONG;
  endfunction : msz
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk(input logic [15:0] w);
    cmp(GROUP_O, w[15:12]);
    cmp({REG_HI_O, DST_MODE_O, SRC_MODE_O, REG_LO_O}, w[11:0]);
    cmp({COND_O, DISP_O}, w[11:0]);
    cmp(VECTOR_O, w[3:0]);
    if (eop.exists(w)) cmp(OP_O, eop[w]);
    if (w[15:12] == 4'ha || w[15:12] == 4'hf) cmp({ILLEGAL_O, OP_O}, 16'h80);
    if (w[15:12] inside {4'h1, 4'h2, 4'h3})
      cmp({OP_O, SIZE_O}, {cpd_pkg::OP_MOVE, msz(w[15:12])});
    if (w[15:12] == 4'h7 && !w[8])
      cmp({OP_O, QUICK_O}, {cpd_pkg::OP_QUICK_LOAD, w[7:0]});
    if (w[15:12] == 4'he && !(w[7:6] == 2'h3 && w[11]))
      cmp({KIND_O, DIR_O}, {w[7:6] == 2'h3 ? w[10:9] : w[4:3], w[8]});
    if (w[15:12] == 4'h0 && w[8] && w[5:3] != 3'h1)
      cmp(KIND_O, w[7:6]);
    if (w[15:12] inside {4'h8, 4'hc} && w[8:4] == 5'h10)
      cmp(MEM_FORM_O, w[3]);
    if (w[15:12] == 4'h9 && !(w[8] && w[5:4] == 2'h0))
      cmp({SIZE_O, DIR_O}, {w[7:6] != 2'h3 ? w[7:6] :
        w[8] ? 2'h2 : 2'h1, w[8]});
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // Result must trail its load by exactly two edges, in order
  always @(posedge REF_CLK_I) begin
    {l2, l1, w2, w1} <= {l1, LOAD_I, w1, WORD_I};
  end
  always @(negedge REF_CLK_I) begin
    stall <= ($urandom % 4) == 0;
    if (!RESET_I) cmp(VALID_O, l2);
    if (!RESET_I && l2) chk(w2);
  end
  initial begin
    #200_000;
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(56));
    repeat (4) @(negedge REF_CLK_I);
    RESET_I = 1'b0;
    foreach (cw[i]) eop[cw[i]] = co[i];
    foreach (cw[i]) fm.push(cw[i]);
    repeat (300) fm.push(16'($urandom));
    while (fm.fifo.size() != 0) @(negedge REF_CLK_I);
    repeat (4) @(negedge REF_CLK_I);
    wrap_up();
  end
endmodule : cpd_decoder_tb
